// >>> logic/dac_pkg.sv
// shared constants, types and helpers for the dma address and cycle control block
package dac_pkg;
    localparam logic [9:0] DAC_INDEX_PORT = 10'h0ec;
    localparam logic [9:0] DAC_DATA_PORT  = 10'h0ed;
    localparam logic [7:0] DAC_CTL_INDEX  = 8'h08;
    localparam logic [9:0] DAC_PAGE_BASE  = 10'h080;
    localparam logic [9:0] DAC_PAGE_MASK  = 10'h3f0;
    localparam logic [7:0] DAC_CTL_RESET  = 8'h38;
    localparam int         DAC_EXT_BIT    = 7;
    localparam int         DAC_HALF_BIT   = 6;
    localparam int         DAC_WS8_LSB    = 4;
    localparam int         DAC_WS16_LSB   = 2;
    localparam int         DAC_CLKSEL_BIT = 1;
    localparam int         DAC_MEMR_BIT   = 0;
    localparam logic [3:0] DAC_REFRESH_PG = 4'hf;
    localparam logic [2:0] DAC_BASE_CLKS  = 3'h2;

    typedef struct packed {
        logic [9:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dac_io_req_t;

    typedef struct packed {
        logic       active;
        logic       word;
        logic [2:0] chan;
        logic [7:0] lo;
        logic [7:0] db;
        logic       adstb;
        logic       memr_n;
        logic       cmd_start;
        logic       cascade_ack;
    } dac_core_t;

    typedef enum logic [1:0] {
        DAC_ARB_IDLE = 2'b00,
        DAC_ARB_DMA  = 2'b01,
        DAC_ARB_REF  = 2'b10
    } dac_arb_state_t;

    // command active clocks per wait-select code
    function automatic logic [2:0] dac_cmd_clks(input logic [1:0] code);
        case (code)
            2'b00:   dac_cmd_clks = 3'h2;
            2'b01:   dac_cmd_clks = 3'h4;
            default: dac_cmd_clks = 3'h3;
        endcase
    endfunction

    // channel number to page slot
    function automatic logic [3:0] dac_page_slot(input logic [2:0] chan);
        case (chan)
            3'h0:    dac_page_slot = 4'h7;
            3'h1:    dac_page_slot = 4'h3;
            3'h2:    dac_page_slot = 4'h1;
            3'h3:    dac_page_slot = 4'h2;
            3'h5:    dac_page_slot = 4'hb;
            3'h6:    dac_page_slot = 4'h9;
            3'h7:    dac_page_slot = 4'ha;
            default: dac_page_slot = 4'h0;
        endcase
    endfunction
endpackage

// >>> logic/dac_wait_ctrl.sv
// forced wait states and channel-ready merge feeding both dma cores
`timescale 1ns/1ps
module dac_wait_ctrl
    import dac_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_sync_n,
    input  wire logic       dma_tick,
    input  wire logic       cmd_start,
    input  wire logic       word,
    input  wire logic [1:0] ws8,
    input  wire logic [1:0] ws16,
    input  wire logic       chan_ready_s,
    output logic            core_ready
);
    logic [2:0] waits_reg;
    logic [2:0] waits_next;
    wire  [1:0] ws_code = word ? ws16 : ws8;
    wire  [2:0] load    = dac_cmd_clks(ws_code) - DAC_BASE_CLKS;

    always_comb
    begin
        waits_next = waits_reg;
        if (cmd_start)
            waits_next = load;
        else if (dma_tick && waits_reg != 3'h0)
            waits_next = waits_reg - 3'h1;
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            waits_reg <= 3'h0;
        else
            waits_reg <= waits_next;
    end

    // one ready source for both cores; a late ready rise costs one more wait
    assign core_ready = (waits_reg == 3'h0) && !cmd_start && chan_ready_s;
endmodule

// >>> logic/dac_hold_arb.sv
// hold request arbiter between the second dma controller and refresh
`timescale 1ns/1ps
module dac_hold_arb
    import dac_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_sync_n,
    input  wire logic dma2_hold_request,
    input  wire logic refresh_out,
    input  wire logic refresh_done,
    input  wire logic hold_ack,
    output logic      hold_req,
    output logic      dma_grant,
    output logic      refresh_grant
);
    dac_arb_state_t state_reg;
    dac_arb_state_t state_next;
    logic           ref_prev_reg;
    logic           ref_pend_reg;
    wire            ref_rise = refresh_out && !ref_prev_reg;
    // a new rise wins over the clear from the finishing refresh
    wire            ref_pend_next = ref_rise || (ref_pend_reg && !refresh_done);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DAC_ARB_IDLE:
                if (hold_ack && dma2_hold_request)
                    state_next = DAC_ARB_DMA;
                else if (hold_ack && ref_pend_reg)
                    state_next = DAC_ARB_REF;
            DAC_ARB_DMA:
                if (!dma2_hold_request)
                    state_next = ref_pend_reg ? DAC_ARB_REF : DAC_ARB_IDLE;
            DAC_ARB_REF:
                if (!ref_pend_next)
                    state_next = dma2_hold_request ? DAC_ARB_DMA : DAC_ARB_IDLE;
            default:
                state_next = DAC_ARB_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_reg    <= DAC_ARB_IDLE;
            ref_prev_reg <= 1'b0;
            ref_pend_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            ref_prev_reg <= refresh_out;
            ref_pend_reg <= ref_pend_next;
        end
    end

    assign hold_req      = dma2_hold_request || ref_pend_reg || state_reg != DAC_ARB_IDLE;
    assign dma_grant     = state_reg == DAC_ARB_DMA;
    assign refresh_grant = state_reg == DAC_ARB_REF;
endmodule

// >>> logic/dac_top.sv
// dma address generation, cycle control and hold arbitration top
`timescale 1ns/1ps
module dac_top
    import dac_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire dac_pkg::dac_io_req_t io_req,
    output logic [7:0]                io_rdata,
    input  wire dac_pkg::dac_core_t   core,
    output logic                      core_ready,
    output logic                      dma_tick,
    input  wire logic                 chan_ready,
    input  wire logic                 refresh_active,
    input  wire logic                 refresh_out,
    input  wire logic                 refresh_done,
    input  wire logic                 dma2_hold_request,
    input  wire logic                 hold_ack,
    output logic                      hold_req,
    output logic                      dma_grant,
    output logic                      refresh_grant,
    output logic [25:0]               addr_out,
    output logic                      addr_oe,
    output logic                      sbhe_n_out,
    output logic [3:0]                be_n_out,
    output logic                      memr_n_out,
    output logic                      cmd_oe,
    output logic                      data_oe
);
    logic        rst_meta_reg;
    logic        rst_sync_n;
    logic        rdy_meta_reg;
    logic        rdy_sync_reg;
    logic [7:0]  index_reg;
    logic [7:0]  ctl_reg;
    logic [7:0]  ctl_next;
    logic [9:0]  page_mem [16];
    logic [7:0]  mid_reg;
    logic        tick_reg;
    logic        memr_d_reg;
    logic [7:0]  rdata_next;
    logic [25:0] addr_next;
    logic [25:0] addr_reg;
    logic        oe_reg;
    logic        sbhe_n_reg;
    logic [3:0]  be_n_reg;
    logic        sbhe_n_next;
    logic [3:0]  be_n_next;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // channel ready comes from the slot
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            rdy_meta_reg <= 1'b1;
            rdy_sync_reg <= 1'b1;
        end
        else
        begin
            rdy_meta_reg <= chan_ready;
            rdy_sync_reg <= rdy_meta_reg;
        end
    end

    // register decode
    wire       ext_en      = ctl_reg[DAC_EXT_BIT];
    wire       half_sel    = ctl_reg[DAC_HALF_BIT] & ext_en;
    wire       clk_sel     = ctl_reg[DAC_CLKSEL_BIT];
    wire       delay_off   = ctl_reg[DAC_MEMR_BIT];
    wire       idx_wr      = io_req.wr && io_req.addr == DAC_INDEX_PORT;
    wire       ctl_hit     = io_req.addr == DAC_DATA_PORT && index_reg == DAC_CTL_INDEX;
    wire       ctl_wr      = io_req.wr && ctl_hit;
    wire       page_hit    = (io_req.addr & DAC_PAGE_MASK) == DAC_PAGE_BASE;
    wire       page_wr     = io_req.wr && page_hit;
    wire [3:0] page_idx    = io_req.addr[3:0];
    wire [9:0] page_rd     = page_mem[page_idx];

    always_comb
    begin
        ctl_next = ctl_reg;
        if (ctl_wr)
            ctl_next = io_req.wdata;
        if (!ctl_next[DAC_EXT_BIT])
            ctl_next[DAC_HALF_BIT] = 1'b0;
        else if (page_wr)
            ctl_next[DAC_HALF_BIT] = ~half_sel;
    end

    always_comb
    begin
        rdata_next = 8'h00;
        if (io_req.rd && io_req.addr == DAC_INDEX_PORT)
            rdata_next = index_reg;
        else if (io_req.rd && ctl_hit)
            rdata_next = {ext_en, half_sel, ctl_reg[5:0]};
        else if (io_req.rd && page_hit)
            rdata_next = half_sel ? {6'h00, page_rd[9:8]} : page_rd[7:0];
    end

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            index_reg <= 8'h00;
            ctl_reg   <= DAC_CTL_RESET;
            io_rdata  <= 8'h00;
        end
        else
        begin
            if (idx_wr)
                index_reg <= io_req.wdata;
            ctl_reg  <= ctl_next;
            io_rdata <= rdata_next;
        end
    end

    // page store; spare slots are plain cpu storage
    always_ff @(posedge mclk)
    begin
        if (page_wr && half_sel)
            page_mem[page_idx][9:8] <= io_req.wdata[1:0];
        else if (page_wr)
            page_mem[page_idx][7:0] <= io_req.wdata;
    end

    // middle address latch, loaded only by the S1 strobe
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            mid_reg <= 8'h00;
        else if (core.adstb)
            mid_reg <= core.db;
    end

    // dma clock rate as a tick; gating mclk itself would skew the cores
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tick_reg <= 1'b0;
        else
            tick_reg <= ~tick_reg;
    end
    assign dma_tick = clk_sel | tick_reg;

    // address assembly; page never receives a carry from the lower parts
    wire [9:0] pg_raw  = page_mem[dac_page_slot(core.chan)];
    wire [9:0] pg_dma  = {pg_raw[9:8] & {2{ext_en}}, pg_raw[7:0]};
    wire [9:0] pg_ref  = page_mem[DAC_REFRESH_PG];

    always_comb
    begin
        addr_next   = 26'h0000000;
        sbhe_n_next = 1'b1;
        be_n_next   = 4'hf;
        if (refresh_active)
            addr_next[25:17] = {pg_ref[9:8] & {2{ext_en}}, pg_ref[7:1]};
        else if (core.word)
        begin
            addr_next   = {pg_dma[9:1], mid_reg, core.lo, 1'b0};
            sbhe_n_next = 1'b0;
            be_n_next   = core.lo[0] ? 4'h3 : 4'hc;
        end
        else
        begin
            addr_next   = {pg_dma, mid_reg, core.lo};
            sbhe_n_next = ~addr_next[0];
            be_n_next   = ~(4'h1 << core.lo[1:0]);
        end
    end

    // cascade acknowledge keeps the address, data and commands off
    wire drive_next = (core.active || refresh_active) && !core.cascade_ack;

    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            addr_reg   <= 26'h0000000;
            oe_reg     <= 1'b0;
            sbhe_n_reg <= 1'b1;
            be_n_reg   <= 4'hf;
        end
        else
        begin
            addr_reg   <= addr_next;
            oe_reg     <= drive_next;
            sbhe_n_reg <= sbhe_n_next;
            be_n_reg   <= be_n_next;
        end
    end

    assign addr_out   = addr_reg;
    assign addr_oe    = oe_reg;
    assign cmd_oe     = oe_reg;
    assign data_oe    = oe_reg && !refresh_active;
    assign sbhe_n_out = sbhe_n_reg;
    assign be_n_out   = be_n_reg;

    // read strobe: falling edge held back one dma tick, rising edge untouched
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            memr_d_reg <= 1'b1;
        else if (dma_tick || core.memr_n)
            memr_d_reg <= core.memr_n;
    end
    assign memr_n_out = core.memr_n | (memr_d_reg & ~delay_off);

    dac_wait_ctrl u_wait (
        .mclk         (mclk),
        .rst_sync_n   (rst_sync_n),
        .dma_tick     (dma_tick),
        .cmd_start    (core.cmd_start),
        .word         (core.word),
        .ws8          (ctl_reg[DAC_WS8_LSB +: 2]),
        .ws16         (ctl_reg[DAC_WS16_LSB +: 2]),
        .chan_ready_s (rdy_sync_reg),
        .core_ready   (core_ready)
    );

    dac_hold_arb u_arb (
        .mclk              (mclk),
        .rst_sync_n        (rst_sync_n),
        .dma2_hold_request (dma2_hold_request),
        .refresh_out       (refresh_out),
        .refresh_done      (refresh_done),
        .hold_ack          (hold_ack),
        .hold_req          (hold_req),
        .dma_grant         (dma_grant),
        .refresh_grant     (refresh_grant)
    );

    property p_top_zero;
        @(posedge mclk) disable iff (!rst_sync_n)
        (!ext_en && !refresh_active && core.active) |=> (addr_out[25:24] == 2'b00);
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("top address bits driven while extension off");

    property p_half_read;
        @(posedge mclk) disable iff (!rst_sync_n)
        (io_req.rd && ctl_hit && !ext_en) |=> (io_rdata[DAC_HALF_BIT] == 1'b0);
    endproperty
    a_half_read: assert property (p_half_read) else $error("half-select read nonzero without extension");

    property p_half_flip;
        @(posedge mclk) disable iff (!rst_sync_n)
        (page_wr && ext_en && !ctl_wr) |=> (half_sel != $past(half_sel));
    endproperty
    a_half_flip: assert property (p_half_flip) else $error("page write did not flip half-select");

    property p_mid_load;
        @(posedge mclk) disable iff (!rst_sync_n)
        core.adstb |=> (mid_reg == $past(core.db)) ##1 (!core.word && !refresh_active
            ? addr_out[15:8] == $past(mid_reg) : 1'b1);
    endproperty
    a_mid_load: assert property (p_mid_load) else $error("middle latch not loaded or not driven");

    property p_word_sbhe;
        @(posedge mclk) disable iff (!rst_sync_n)
        (core.word && !refresh_active) |=> (sbhe_n_out == 1'b0 && addr_out[0] == 1'b0);
    endproperty
    a_word_sbhe: assert property (p_word_sbhe) else $error("word cycle high-byte-enable or bit 0 not low");

    property p_cascade_off;
        @(posedge mclk) disable iff (!rst_sync_n)
        core.cascade_ack [*2] |-> (!addr_oe && !cmd_oe && !data_oe);
    endproperty
    a_cascade_off: assert property (p_cascade_off) else $error("bus driven during cascade acknowledge");

    property p_memr_delay;
        @(posedge mclk) disable iff (!rst_sync_n)
        ($fell(core.memr_n) && !delay_off) |-> memr_n_out;
    endproperty
    a_memr_delay: assert property (p_memr_delay) else $error("read strobe fell without delay");

    property p_fast_clk;
        @(posedge mclk) disable iff (!rst_sync_n)
        (!clk_sel && dma_tick) |=> (clk_sel || !dma_tick);
    endproperty
    a_fast_clk: assert property (p_fast_clk) else $error("dma tick rate wrong for clock select");

    property p_ref_hold;
        @(posedge mclk) disable iff (!rst_sync_n)
        $rose(refresh_out) |-> ##[1:2] hold_req;
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("refresh rise gave no hold request");
endmodule

// >>> tb/dac_slot_dev.sv
// slot device model that stretches dma cycles through channel ready
`timescale 1ns/1ps
module dac_slot_dev
(
    input  wire logic       mclk,
    input  wire logic       cmd_start,
    input  wire logic [3:0] stall,
    output logic            chan_ready
);
    logic [3:0] cnt_reg = 4'h0;

    // pulled low at command start, before the last forced wait can end
    always_ff @(posedge mclk)
    begin
        if (cmd_start)
            cnt_reg <= stall;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end

    // pull-up keeps the line high whenever nobody stalls
    assign chan_ready = (cnt_reg == 4'h0) && !(cmd_start && stall != 4'h0);
endmodule

// >>> tb/test_dma_address_and_cycle_control.sv
// self-checking bench for dma address and cycle control
`timescale 1ns/1ps
module test_dma_address_and_cycle_control;
    import dac_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    dac_io_req_t io_req = '0;
    dac_core_t   core = '0;
    logic [7:0]  io_rdata, rdq, m;
    logic        core_ready, dma_tick, chan_ready, t0, w;
    logic        refresh_active = 1'b0, refresh_out = 1'b0, refresh_done = 1'b0;
    logic        dma2_hold_request = 1'b0, hold_ack = 1'b0;
    logic        hold_req, dma_grant, refresh_grant, addr_oe, sbhe_n_out, memr_n_out, cmd_oe, data_oe;
    logic [25:0] addr_out;
    logic [3:0]  be_n_out;
    logic [3:0]  stall = 4'h0;
    logic [9:0]  pg, pa;
    int          n_mismatch = 0, samples_checked = 0, lows;
    logic [2:0]  chn [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [3:0]  slt [7] = '{4'h7, 4'h3, 4'h1, 4'h2, 4'hb, 4'h9, 4'ha};

    always #10 mclk = ~mclk;

    dac_top dac_top_i (.mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata), .core(core),
        .core_ready(core_ready), .dma_tick(dma_tick), .chan_ready(chan_ready), .refresh_active(refresh_active),
        .refresh_out(refresh_out), .refresh_done(refresh_done), .dma2_hold_request(dma2_hold_request),
        .hold_ack(hold_ack), .hold_req(hold_req), .dma_grant(dma_grant), .refresh_grant(refresh_grant),
        .addr_out(addr_out), .addr_oe(addr_oe), .sbhe_n_out(sbhe_n_out), .be_n_out(be_n_out),
        .memr_n_out(memr_n_out), .cmd_oe(cmd_oe), .data_oe(data_oe));

    dac_slot_dev dac_slot_dev_i (.mclk(mclk), .cmd_start(core.cmd_start), .stall(stall), .chan_ready(chan_ready));

    function automatic logic [25:0] exp_addr(input logic [9:0] p, input logic [7:0] mi, input logic [7:0] l,
                                             input logic wd, input logic ext);
        logic [9:0] q;
        q = ext ? p : {2'b00, p[7:0]};
        exp_addr = wd ? {q[9:1], mi, l, 1'b0} : {q, mi, l};
    endfunction

    function automatic logic [3:0] exp_be(input logic [7:0] l, input logic wd);
        exp_be = wd ? (l[0] ? 4'h3 : 4'hc) : ~(4'h1 << l[1:0]);
    endfunction

    function automatic int exp_clks(input logic [1:0] c);
        exp_clks = (c == 2'b00) ? 2 : ((c == 2'b01) ? 4 : 3);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // strobe held for exactly one taking edge, then an idle cycle
    task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] d);
        io_req.addr = a;
        io_req.wr = wr;
        io_req.rd = ~wr;
        io_req.wdata = d;
        @(negedge mclk);
        rdq = io_rdata;
        io_req.wr = 1'b0;
        io_req.rd = 1'b0;
        @(negedge mclk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        io(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
        io(1'b0, a, 8'h00);
        chk(rdq, e);
    endtask

    task automatic ctl(input logic [7:0] v);
        wr(DAC_INDEX_PORT, DAC_CTL_INDEX);
        wr(DAC_DATA_PORT, v);
    endtask

    task automatic run_cmd;
        lows = 0;
        core.active = 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            core.cmd_start = (k == 0);
            #1;
            if (core_ready !== 1'b1)
                lows++;
            @(negedge mclk);
        end
        chk(core_ready, 1'b1);
    endtask

    initial
    begin
        #1000000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        core.memr_n = 1'b1;
        void'($urandom(83));
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        wr(DAC_INDEX_PORT, DAC_CTL_INDEX);
        rdchk(DAC_DATA_PORT, 8'h38);
        run_cmd();
        chk(lows inside {2, 3}, 1'b1);
        ctl(8'h78);
        rdchk(DAC_DATA_PORT, 8'h38);
        ctl(8'hb8);
        m = 8'($urandom);
        wr(10'h084, m);
        rdchk(DAC_DATA_PORT, 8'hf8);
        wr(10'h084, 8'h02);
        rdchk(10'h084, m);
        rdchk(DAC_DATA_PORT, 8'hb8);
        ctl(8'hf8);
        for (int i = 0; i < 7; i++)
        begin
            pg = 10'($urandom);
            m = 8'($urandom);
            w = (chn[i] > 3'h3);
            pa = DAC_PAGE_BASE | {6'h0, slt[i]};
            wr(pa, {6'h0, pg[9:8]});
            wr(pa, pg[7:0]);
            rdchk(pa, {6'h0, pg[9:8]});
            core.chan = chn[i];
            core.word = w;
            core.active = 1'b1;
            core.db = m;
            core.adstb = 1'b1;
            core.lo = 8'($urandom);
            @(negedge mclk);
            core.adstb = 1'b0;
            core.db = ~m;
            core.lo = core.lo + 8'h1;
            repeat (2) @(negedge mclk);
            chk(addr_out, exp_addr(pg, m, core.lo, w, 1'b1));
            chk({addr_oe, sbhe_n_out, be_n_out}, {1'b1, w ? 1'b0 : ~core.lo[0], exp_be(core.lo, w)});
        end
        core.cascade_ack = 1'b1;
        repeat (2) @(negedge mclk);
        chk({addr_oe, cmd_oe, data_oe}, 3'b000);
        core.cascade_ack = 1'b0;
        ctl(8'h38);
        chk(addr_out, exp_addr(pg, m, core.lo, w, 1'b0));
        ctl(8'hf8);
        pa = 10'($urandom);
        wr(10'h08f, {6'h0, pa[9:8]});
        wr(10'h08f, pa[7:0]);
        core.active = 1'b0;
        refresh_active = 1'b1;
        repeat (2) @(negedge mclk);
        chk(addr_out, {pa[9:1], 17'h0});
        refresh_active = 1'b0;
        for (int c = 0; c < 4; c++)
            for (int wd = 0; wd < 2; wd++)
            begin
                ctl(wd == 0 ? {2'b00, 2'(c), 2'(3 - c), 2'b10} : {2'b00, 2'(3 - c), 2'(c), 2'b10});
                core.word = wd[0];
                run_cmd();
                chk(lows, exp_clks(2'(c)) - 1);
            end
        stall = 4'h6;
        run_cmd();
        chk(lows > 6, 1);
        stall = 4'h0;
        ctl(8'h3a);
        chk(dma_tick, 1'b1);
        core.memr_n = 1'b0;
        #1 chk(memr_n_out, 1'b1);
        @(negedge mclk);
        chk(memr_n_out, 1'b0);
        core.memr_n = 1'b1;
        #1 chk(memr_n_out, 1'b1);
        ctl(8'h3b);
        core.memr_n = 1'b0;
        #1 chk(memr_n_out, 1'b0);
        @(negedge mclk);
        core.memr_n = 1'b1;
        ctl(8'h38);
        t0 = dma_tick;
        @(negedge mclk);
        chk(t0 ^ dma_tick, 1'b1);
        dma2_hold_request = 1'b1;
        #1 chk(hold_req, 1'b1);
        @(negedge mclk);
        hold_ack = 1'b1;
        repeat (2) @(negedge mclk);
        chk(dma_grant, 1'b1);
        refresh_out = 1'b1;
        @(negedge mclk);
        dma2_hold_request = 1'b0;
        repeat (2) @(negedge mclk);
        chk({hold_req, refresh_grant, dma_grant}, 3'b110);
        refresh_done = 1'b1;
        @(negedge mclk);
        refresh_done = 1'b0;
        hold_ack = 1'b0;
        refresh_out = 1'b0;
        repeat (2) @(negedge mclk);
        chk(hold_req, 1'b0);
        refresh_out = 1'b1;
        repeat (2) @(negedge mclk);
        chk(hold_req, 1'b1);
        end_sim();
    end
endmodule
